//--- eag_consts.svh
/*
  Constants for the effective-address generator: mode codes,
  interrupt-mask levels and the page-zero high byte.
  Assumes it is included once per compile unit by bare name.
*/
`ifndef EAG_CONSTS_SVH
`define EAG_CONSTS_SVH

// ----------------------------------------------------------------
// addressing mode codes (mode field of eag_req_t)
// ----------------------------------------------------------------
`define EAG_MODE_INH      4'h0
`define EAG_MODE_IMM      4'h1
`define EAG_MODE_DIR_S    4'h2
`define EAG_MODE_DIR_L    4'h3
`define EAG_MODE_IDX_0    4'h4
`define EAG_MODE_IDX_S    4'h5
`define EAG_MODE_IDX_L    4'h6
`define EAG_MODE_IND_S    4'h7
`define EAG_MODE_IND_L    4'h8
`define EAG_MODE_INDX_S   4'h9
`define EAG_MODE_INDX_L   4'hA
`define EAG_MODE_REL      4'hB

// ----------------------------------------------------------------
// interrupt mask levels, mask reset value and page-zero high byte
// ----------------------------------------------------------------
`define EAG_IMASK_SET     2'h3
`define EAG_IMASK_CLR     2'h0
`define EAG_IMASK_RST     2'h3
`define EAG_PAGE0_HI      8'h00

`endif

//--- eag_pkg.sv
/*
  Types shared by the effective-address generator.
  Assumes eag_consts.svh supplies the numeric constants.
*/
package eag_pkg;

  typedef enum logic [1:0]
  {
    EAG_OP_NONE,
    EAG_OP_MASK,
    EAG_OP_UNMASK
  } eag_imask_op_t;

  // one decoded instruction request from the sequencer
  typedef struct packed
  {
    logic [3:0]    mode;
    logic          use_y;
    logic          rmw;
    eag_imask_op_t imask_op;
  } eag_req_t;

  // result of one address computation
  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0]  imm;
    logic [1:0]  length;
    logic        is_imm;
    logic        illegal;
  } eag_res_t;

endpackage

//--- eag_core.sv
/*
  Effective-address generator and instruction-length decoder.
  Assumes a byte-wide memory that answers combinationally from the
  registered address, so read data stands in the cycle in which the
  registered strobe stands; the opcode is already taken by the
  sequencer, and index registers and PC are held outside on the same
  clock. Index registers are read live while the result is formed.
*/
// Behaviour
// [RULE1] short forms keep operand addresses in page zero, fewer bytes
// [RULE2] long forms reach any address of the 64 Kbyte space
// [RULE3] read-modify-write operations accept short forms only
// [RULE4] inherent instructions are one byte, no operand fetch
// [RULE5] immediate instructions are two bytes, second byte is the operand
// [RULE6] short direct fetches one address byte, range 00 to FF
// [RULE7] long direct fetches a two-byte address word
// [RULE8] indexed address is unsigned sum of X or Y and offset
// [RULE9] indexed without offset uses index alone, no byte fetched
// [RULE10] short indexed adds one offset byte, carry kept, up to 1FE
// [RULE11] long indexed adds index to a two-byte offset word
// [RULE12] indirect: byte after opcode is pointer address, pointer read from memory
// [RULE13] short indirect reads one-byte pointer, range 00 to FF
// [RULE14] long indirect reads two-byte pointer from page-zero pointer address
// [RULE15] indirect indexed adds X or Y to the pointer value
// [RULE16] short indirect indexed sum spans 00 to 1FE
// [RULE17] mask instruction sets interrupt mask to level 3
// [RULE18] unmask instruction lowers interrupt mask to level 0
// [RULE19] relative branch adds signed 8-bit displacement to PC
// [RULE20] long indexed sums wrap modulo 64 Kbyte without fault
`include "eag_consts.svh"

module eag_core
  import eag_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        start_i,
  input  wire eag_req_t    req_i,
  input  wire logic [7:0]  idx_x_i,
  input  wire logic [7:0]  idx_y_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  mem_data_i,
  output logic             mem_rd_o,
  output logic [15:0]      mem_addr_o,
  output logic             busy_o,
  output logic             done_o,
  output eag_res_t         res_o,
  output logic [15:0]      branch_pc_o,
  output logic [1:0]       imask_o
);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_BYTE1,
    ST_BYTE2,
    ST_PTR_HI,
    ST_PTR_LO,
    ST_FINISH
  } eag_state_t;

  eag_state_t  state_reg;
  eag_req_t    req_reg;
  logic [15:0] fetch_pc_reg;
  logic [7:0]  b1_reg;
  logic [15:0] base_reg;
  logic [7:0]  ptr_addr_reg;
  logic [1:0]  len_reg;
  logic        hi_taken_reg;

  logic [7:0]  index_sel;
  logic        is_long;
  logic        is_ind;
  logic        is_indexed;
  logic [1:0]  ops_bytes;
  logic        rd_phase;

  assign index_sel  = req_reg.use_y ? idx_y_i : idx_x_i;
  assign is_long    = (req_reg.mode == `EAG_MODE_DIR_L) || (req_reg.mode == `EAG_MODE_IDX_L)
                   || (req_reg.mode == `EAG_MODE_IND_L) || (req_reg.mode == `EAG_MODE_INDX_L);
  assign is_ind     = (req_reg.mode == `EAG_MODE_IND_S) || (req_reg.mode == `EAG_MODE_IND_L)
                   || (req_reg.mode == `EAG_MODE_INDX_S) || (req_reg.mode == `EAG_MODE_INDX_L);
  assign is_indexed = (req_reg.mode == `EAG_MODE_IDX_S) || (req_reg.mode == `EAG_MODE_IDX_L)
                   || (req_reg.mode == `EAG_MODE_INDX_S) || (req_reg.mode == `EAG_MODE_INDX_L);

  // operand bytes after the opcode for each mode
  always_comb
  begin
    case (req_reg.mode)
      `EAG_MODE_INH:    ops_bytes = 2'd0;  // [RULE4]
      `EAG_MODE_IDX_0:  ops_bytes = 2'd0;  // [RULE9]
      `EAG_MODE_IMM:    ops_bytes = 2'd1;  // [RULE5]
      `EAG_MODE_DIR_S:  ops_bytes = 2'd1;  // [RULE6]
      `EAG_MODE_IDX_S:  ops_bytes = 2'd1;  // [RULE10]
      `EAG_MODE_REL:    ops_bytes = 2'd1;
      `EAG_MODE_DIR_L:  ops_bytes = 2'd2;  // [RULE7]
      `EAG_MODE_IDX_L:  ops_bytes = 2'd2;  // [RULE11]
      default:          ops_bytes = 2'd1;  // indirect: one pointer-address byte [RULE12]
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg    <= ST_IDLE;
      req_reg      <= '0;
      fetch_pc_reg <= 16'h0000;
      b1_reg       <= 8'h00;
      base_reg     <= 16'h0000;
      ptr_addr_reg <= 8'h00;
      len_reg      <= 2'd0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_i)
          begin
            req_reg      <= req_i;
            fetch_pc_reg <= pc_i + 16'h0001;
            state_reg    <= ST_BYTE1;
          end
        end
        ST_BYTE1:
        begin
          len_reg <= ops_bytes;
          // illegal long rmw and no-byte modes finish without a fetch
          if (ops_bytes == 2'd0 || (req_reg.rmw && is_long))  // [RULE3]
            state_reg <= ST_FINISH;
          else
          begin
            fetch_pc_reg <= fetch_pc_reg + 16'h0001;
            state_reg    <= ST_BYTE2;
          end
        end
        ST_BYTE2:
        begin
          b1_reg <= mem_data_i;
          if (is_ind)
          begin
            ptr_addr_reg <= mem_data_i;  // page-zero pointer address [RULE12]
            state_reg    <= ST_PTR_HI;
          end
          else if (ops_bytes == 2'd2)
          begin
            base_reg[15:8] <= mem_data_i;  // high byte first
            fetch_pc_reg   <= fetch_pc_reg + 16'h0001;
            state_reg      <= ST_PTR_LO;
          end
          else
          begin
            base_reg  <= {`EAG_PAGE0_HI, mem_data_i};  // [RULE1] [RULE6]
            state_reg <= ST_FINISH;
          end
        end
        ST_PTR_HI:
        begin
          // pointer word read starts here; byte pointer takes one read
          state_reg <= ST_PTR_LO;
        end
        ST_PTR_LO:
        begin
          // long pointer: high byte first, then one more cycle for the low byte
          if (is_ind && is_long && !hi_taken_reg)
          begin
            base_reg  <= {mem_data_i, 8'h00};  // [RULE14]
            state_reg <= ST_PTR_LO;
          end
          else if (is_ind && is_long)
          begin
            base_reg  <= {base_reg[15:8], mem_data_i};  // [RULE14]
            state_reg <= ST_FINISH;
          end
          else if (is_ind)
          begin
            base_reg  <= {`EAG_PAGE0_HI, mem_data_i};  // [RULE13] [RULE16]
            state_reg <= ST_FINISH;
          end
          else
          begin
            base_reg[7:0] <= mem_data_i;  // [RULE7] [RULE11]
            state_reg     <= ST_FINISH;
          end
        end
        ST_FINISH:
        begin
          state_reg <= ST_IDLE;
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pointer word progress
  // ----------------------------------------------------------------
  // cleared while idle so a flag left by one instruction can never let
  // the next long pointer skip its high byte
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      hi_taken_reg <= 1'b0;
    else if (state_reg == ST_IDLE)
      hi_taken_reg <= 1'b0;
    else if (state_reg == ST_PTR_LO && is_ind && is_long)
      hi_taken_reg <= 1'b1;
  end

  // memory read request: code bytes from fetch pc, pointers from page zero
  // a long rmw request never touches memory, it only reports illegal
  assign rd_phase = (state_reg == ST_BYTE1 && ops_bytes != 2'd0 && !(req_reg.rmw && is_long))
                 || (state_reg == ST_BYTE2 && !is_ind && ops_bytes == 2'd2)
                 || (state_reg == ST_PTR_HI)
                 || (state_reg == ST_PTR_LO && is_ind && is_long && !hi_taken_reg);

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mem_rd_o   <= 1'b0;
      mem_addr_o <= 16'h0000;
    end
    else
    begin
      mem_rd_o <= rd_phase;
      if (state_reg == ST_PTR_HI)
        mem_addr_o <= {`EAG_PAGE0_HI, ptr_addr_reg};  // [RULE14]
      else if (state_reg == ST_PTR_LO)
        mem_addr_o <= {`EAG_PAGE0_HI, ptr_addr_reg + 8'h01};
      else
        mem_addr_o <= fetch_pc_reg;
    end
  end

  // ----------------------------------------------------------------
  // result
  // ----------------------------------------------------------------
  logic [15:0] ea_next;
  logic [15:0] br_next;

  // index registers are read live here, so they must hold until done
  always_comb
  begin
    ea_next = base_reg;
    if (req_reg.mode == `EAG_MODE_IDX_0)
      ea_next = {`EAG_PAGE0_HI, index_sel};  // [RULE9]
    else if (is_indexed)
      ea_next = base_reg + {8'h00, index_sel};  // [RULE8] [RULE10] [RULE15] [RULE20]
    br_next = fetch_pc_reg + {{8{b1_reg[7]}}, b1_reg};  // [RULE19]
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      done_o      <= 1'b0;
      busy_o      <= 1'b0;
      res_o       <= '0;
      branch_pc_o <= 16'h0000;
    end
    else
    begin
      done_o <= (state_reg == ST_FINISH);
      busy_o <= (state_reg != ST_IDLE && state_reg != ST_FINISH) || (state_reg == ST_IDLE && start_i);
      if (state_reg == ST_FINISH)
      begin
        res_o.addr    <= ea_next;  // [RULE2]
        res_o.imm     <= b1_reg;   // [RULE5]
        res_o.length  <= len_reg;
        res_o.is_imm  <= (req_reg.mode == `EAG_MODE_IMM);
        res_o.illegal <= req_reg.rmw && is_long;  // [RULE3]
        branch_pc_o   <= br_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt mask level
  // ----------------------------------------------------------------
  // changes at the start edge itself; the decode still runs on to done
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      imask_o <= `EAG_IMASK_RST;
    else if (start_i && state_reg == ST_IDLE && req_i.mode == `EAG_MODE_INH)
    begin
      if (req_i.imask_op == EAG_OP_MASK)
        imask_o <= `EAG_IMASK_SET;  // [RULE17]
      else if (req_i.imask_op == EAG_OP_UNMASK)
        imask_o <= `EAG_IMASK_CLR;  // [RULE18]
    end
  end

endmodule

//--- eag_core_chk.sv
/*
  Checker for eag_core, bound to its ports.
  Assumes eag_pkg and eag_consts.svh come first.
*/
`include "eag_consts.svh"

module eag_core_chk
  import eag_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        start_i,
  input wire eag_req_t    req_i,
  input wire logic [7:0]  idx_x_i,
  input wire logic [7:0]  idx_y_i,
  input wire logic [15:0] pc_i,
  input wire logic        mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire eag_res_t    res_o,
  input wire logic [1:0]  imask_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        take;
  logic        lng;
  logic        skip;
  logic [3:0]  md_reg;
  logic        y_reg;
  logic        ill_reg;
  logic [15:0] pc_reg;
  assign take = start_i && !busy_o;
  assign lng  = req_i.mode inside {`EAG_MODE_DIR_L, `EAG_MODE_IDX_L, `EAG_MODE_IND_L, `EAG_MODE_INDX_L};
  assign skip = req_i.mode inside {`EAG_MODE_INH, `EAG_MODE_IDX_0};
  // -------------------------------------------------------------
  // request capture: results are judged against the op behind them
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      md_reg  <= 4'h0;
      y_reg   <= 1'b0;
      ill_reg <= 1'b0;
      pc_reg  <= 16'h0000;
    end
    else if (take)
    begin
      md_reg  <= req_i.mode;
      y_reg   <= req_i.use_y;
      ill_reg <= req_i.rmw && lng;
      pc_reg  <= pc_i;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  AST_MASK: assert property (
    take && req_i.mode == `EAG_MODE_INH && req_i.imask_op == EAG_OP_MASK |-> ##[1:2] imask_o == `EAG_IMASK_SET)
    else $error("mask level not raised");
  AST_UNMASK: assert property (
    take && req_i.mode == `EAG_MODE_INH && req_i.imask_op == EAG_OP_UNMASK |-> ##[1:2] imask_o == `EAG_IMASK_CLR)
    else $error("mask level not lowered");
  AST_NO_FETCH: assert property (
    take && skip |=> !mem_rd_o [*2])
    else $error("operand byte fetched for a one-byte form");
  AST_RMW_SHORT: assert property (
    take && req_i.rmw && lng |=> !mem_rd_o [*2])
    else $error("long form fetched for read-modify-write");
  AST_FETCH: assert property (
    take && !skip && !(req_i.rmw && lng) |-> ##[1:4] (mem_rd_o && mem_addr_o == pc_reg + 16'h0001))
    else $error("byte after opcode not read");
  AST_ILLEGAL: assert property (
    done_o |-> res_o.illegal == ill_reg)
    else $error("illegal flag wrong");
  AST_PAGE0: assert property (
    done_o && md_reg inside {`EAG_MODE_DIR_S, `EAG_MODE_IND_S} |-> res_o.addr[15:8] == `EAG_PAGE0_HI)
    else $error("short form left page zero");
  AST_IDX0: assert property (
    done_o && md_reg == `EAG_MODE_IDX_0 |-> res_o.addr == {8'h00, y_reg ? idx_y_i : idx_x_i})
    else $error("no-offset index address wrong");
  AST_SHORT_IDX: assert property (
    done_o && md_reg inside {`EAG_MODE_IDX_S, `EAG_MODE_INDX_S} |-> res_o.addr[15:9] == 7'h00)
    else $error("short indexed sum above 1FE");
endmodule

bind eag_core eag_core_chk eag_core_chk_i (.mclk_i, .sys_rst_i, .start_i, .req_i, .idx_x_i, .idx_y_i,
  .pc_i, .mem_rd_o, .mem_addr_o, .busy_o, .done_o, .res_o, .imask_o);

//--- eag_mem.sv
/*
  Memory model answering reads of the address generator.
  Assumes read data is wanted while the registered request stands.
*/
module eag_mem
(
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output logic [7:0]       mem_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // content is the inverted low address byte; the raw byte shows while no read stands
  always_comb
  begin
    if (mem_rd_i)
      mem_data_o = ~mem_addr_i[7:0];
    else
      mem_data_o = mem_addr_i[7:0];
  end
endmodule

//--- eag_core_tb.sv
/*
  Self-checking bench for eag_core.
  Assumes eag_pkg, eag_mem and eag_core_chk are compiled first.
*/
`include "eag_consts.svh"

module eag_core_tb
  import eag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        start_i = 1'b0;
  eag_req_t    req_i = '0;
  logic [7:0]  idx_x_i = 8'hF0;
  logic [7:0]  idx_y_i = 8'h0F;
  logic [15:0] pc_i = 16'h0000;
  logic [7:0]  mem_data_i;
  logic        mem_rd_o, busy_o, done_o;
  logic [15:0] mem_addr_o, branch_pc_o;
  eag_res_t    res_o;
  logic [1:0]  imask_o;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  eag_core eag_core_i (.mclk_i, .sys_rst_i, .start_i, .req_i, .idx_x_i, .idx_y_i, .pc_i, .mem_data_i,
    .mem_rd_o, .mem_addr_o, .busy_o, .done_o, .res_o, .branch_pc_o, .imask_o);
  eag_mem eag_mem_i (.mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));
  initial forever #5 mclk_i = ~mclk_i;
  // -------------------------------------------------------------
  // expectations and shared tasks
  // -------------------------------------------------------------
  function automatic logic [7:0] mm(input logic [15:0] a);
    mm = ~a[7:0];
  endfunction
  function automatic logic [15:0] ea(input logic [3:0] m, input logic [15:0] p, input logic [7:0] ix);
    logic [7:0] b1, b2, q1, q2;
    b1 = mm(p + 16'h0001);
    b2 = mm(p + 16'h0002);
    q1 = mm({8'h00, b1});
    q2 = mm({8'h00, b1} + 16'h0001);
    case (m)
      `EAG_MODE_DIR_S:  ea = {8'h00, b1};
      `EAG_MODE_DIR_L:  ea = {b1, b2};
      `EAG_MODE_IDX_0:  ea = {8'h00, ix};
      `EAG_MODE_IDX_S:  ea = {8'h00, b1} + {8'h00, ix};
      `EAG_MODE_IDX_L:  ea = {b1, b2} + {8'h00, ix};
      `EAG_MODE_IND_S:  ea = {8'h00, q1};
      `EAG_MODE_IND_L:  ea = {q1, q2};
      `EAG_MODE_INDX_S: ea = {8'h00, q1} + {8'h00, ix};
      default:          ea = {q1, q2} + {8'h00, ix};
    endcase
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input logic [3:0] m, input logic u, input logic r, input eag_imask_op_t op, input logic [15:0] p);
    int n;
    n = 0;
    @(negedge mclk_i);
    req_i = '{m, u, r, op};
    pc_i = p;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    chk("busy", busy_o, 1'b1);
    while (done_o !== 1'b1 && n < 12)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk("done", done_o, 1'b1);
    chk("busy_done", busy_o, 1'b0);
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_modes(input logic [15:0] p);
    logic [3:0] m;
    logic [7:0] b1;
    logic       il;
    b1 = mm(p + 16'h0001);
    for (int i = 0; i < 12; i++)
      for (int u = 0; u < 2; u++)
        for (int r = 0; r < 2; r++)
        begin
          m = 4'(i);
          il = r == 1 && m inside {`EAG_MODE_DIR_L, `EAG_MODE_IDX_L, `EAG_MODE_IND_L, `EAG_MODE_INDX_L};
          go(m, 1'(u), 1'(r), EAG_OP_NONE, p);
          chk("illegal", res_o.illegal, il);
          chk("is_imm", res_o.is_imm, m == `EAG_MODE_IMM);
          if (m == `EAG_MODE_IMM)
            chk("imm", res_o.imm, b1);
          if (m == `EAG_MODE_REL)
            chk("branch", branch_pc_o, p + 16'h0002 + {{8{b1[7]}}, b1});
          if (!il)
            chk("length", res_o.length, m inside {`EAG_MODE_INH, `EAG_MODE_IDX_0} ? 2'h0 :
              m inside {`EAG_MODE_DIR_L, `EAG_MODE_IDX_L} ? 2'h2 : 2'h1);
          if (!il && m >= `EAG_MODE_DIR_S && m <= `EAG_MODE_INDX_L)
            chk("addr", res_o.addr, ea(m, p, u ? idx_y_i : idx_x_i));
        end
  endtask
  task automatic t_imask();
    go(`EAG_MODE_INH, 1'b0, 1'b0, EAG_OP_UNMASK, 16'h2000);
    chk("imask", imask_o, `EAG_IMASK_CLR);
    go(`EAG_MODE_INH, 1'b0, 1'b0, EAG_OP_MASK, 16'h2001);
    chk("imask", imask_o, `EAG_IMASK_SET);
    go(`EAG_MODE_INH, 1'b0, 1'b0, EAG_OP_UNMASK, 16'h2002);
    sys_rst_i = 1'b1;
    @(negedge mclk_i);
    chk("imask_rst", imask_o, `EAG_IMASK_RST);
    sys_rst_i = 1'b0;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      results();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    chk("imask_rst", imask_o, `EAG_IMASK_RST);
    t_imask();
    t_modes(16'h30FE); // wraps the long indirect indexed sums past FFFF
    t_modes(16'h4020); // short sums with X carry into bit 8
    t_modes(16'h1080); // forward branch
    results();
  end
endmodule
